// >>> logic/cfc_clock_ctrl.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
// Operation
// RULE1: PHY clock control written as 16 bits, key 5A upper, data lower.
// RULE2: Source select 00 and 01 both pick PLL1; reset 01; 10/11 prohibited.
// RULE3: PHY divider 000 /1, 001 /2, 011 /4; reset 011.
// RULE4: PHY control bits 5..3 read zero; software writes zero.
// RULE5: PHY control steers only the PHY clock output.
// RULE6: Outside party holds the PHY in reset while clocks change.
// RULE7: Core clock via multiplier; peripheral via multiplier or divider.
// RULE8: Multiplier resets to one.
// RULE9: Software preloads and stops watchdog before a multiplier change.
// RULE10: Multiplier write, no defer: pause core, run watchdog, bus clock on.
// RULE11: Watchdog overflow applies new clocks, resumes, and stops watchdog.
// RULE12: No external interrupt edge detection while clocks are paused.
// RULE13: Deferred-mode write does not change clocks immediately.
// RULE14: Divider-only change switches at once, no watchdog count.
// RULE15: Peripheral divider resets to 011.
// RULE16: Software writes only divider values legal for the mode.
// RULE17: Mode pins sampled at power-on and deferred standby entry.
// RULE18: Deferred settings take effect only after standby is left.
// RULE19: Software follows the fixed deferred mode change sequence.
// RULE20: After deferred standby exit, run with the value written before.
// RULE21: Handler clears standby bit, else standby is entered again.
// RULE22: After deferred multiplier change, divider-only writes never switch.
// RULE23: Multiplier 000 is x1, 001 is x2; others prohibited.
// RULE24: Peripheral divider 000 /1, 001 /2, 011 /4; others prohibited.
// RULE25: PHY control write with wrong key is ignored.
module cfc_clock_ctrl (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire cfc_pkg::cfc_bus_s i_bus,
    input  wire logic              i_sleep,
    input  wire logic              i_wake_irq,
    input  wire logic [2:0]        i_mode_pins,
    output logic [15:0]            o_rdata,
    output cfc_pkg::cfc_freq_s     o_clk_setting,
    output logic [2:0]             o_clock_mode,
    output logic                   o_core_clk_run,
    output logic                   o_bus_clk_run,
    output logic                   o_edge_detect_en,
    output logic                   o_phy_clk
);
    import cfc_pkg::*;

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    cfc_state_e state;
    cfc_state_e next_state;
    cfc_freq_s  freq;
    cfc_freq_s  next_applied;
    logic [1:0] phy_src;
    logic [2:0] phy_div;
    logic       standby_request_bit_req;
    logic       defer;
    logic       wdt_run;
    logic [2:0] wdt_cks;
    logic       pending;
    logic [1:0] por_cnt;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic       wake_s1;
    logic       wake_s2;
    logic [7:0] wdt_count;
    logic       wdt_ovf;
    logic [15:0] rd_mux;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire [7:0] wkey     = i_bus.wdata[15:8];
    wire       wr_phy   = i_bus.wr && i_bus.addr == OFS_PHY_CTRL
                          && wkey == KEY_PHY;                     // [RULE1] [RULE25]
    wire       wr_freq  = i_bus.wr && i_bus.addr == OFS_FREQ
                          && state == CFC_RUN;
    wire       wr_standby_request_bit  = i_bus.wr && i_bus.addr == OFS_STANDBY_REQUEST_BIT;
    wire       wr_wcnt  = i_bus.wr && i_bus.addr == OFS_WDT_CNT
                          && wkey == KEY_WDT_CNT;
    wire       wr_wcsr  = i_bus.wr && i_bus.addr == OFS_WDT_CSR
                          && wkey == KEY_WDT_CSR;
    wire [2:0] new_mul  = i_bus.wdata[FREQ_MUL_LSB +: 3];
    wire [2:0] new_div  = i_bus.wdata[FREQ_DIV_LSB +: 3];
    wire       mult_chg = wr_freq && new_mul != freq.mult;

    // ----------------------------------------------------------------
    // Sequencing conditions
    // ----------------------------------------------------------------
    wire start_pause = wr_freq && !defer && mult_chg;             // [RULE10]
    wire apply_div   = wr_freq && !defer && !mult_chg
                       && !pending;                               // [RULE14] [RULE22]
    wire apply_all   = wdt_ovf && (state == CFC_PAUSE
                       || (state == CFC_WAKE && pending));        // [RULE11] [RULE20]
    wire go_standby  = i_sleep && standby_request_bit_req && state == CFC_RUN;   // [RULE21]
    wire wdt_cnt_en  = wdt_run || state == CFC_PAUSE
                       || state == CFC_WAKE;                      // [RULE10]
    wire catch_por   = por_cnt == POR_CATCH;

    // Next state of the clock sequencer
    always_comb begin
        next_state = state;
        case (state)
            CFC_RUN: begin
                if (start_pause) begin
                    next_state = CFC_PAUSE;                       // [RULE10]
                end else if (go_standby) begin
                    next_state = CFC_STANDBY;
                end
            end
            CFC_PAUSE: begin
                if (wdt_ovf) begin
                    next_state = CFC_RUN;                         // [RULE11]
                end
            end
            CFC_STANDBY: begin
                if (wake_s2) begin
                    next_state = CFC_WAKE;
                end
            end
            CFC_WAKE: begin
                if (wdt_ovf) begin
                    next_state = CFC_RUN;
                end
            end
            default: next_state = CFC_RUN;
        endcase
    end

    // Applied setting: whole on overflow, divider alone when allowed
    assign next_applied = apply_all ? freq
                        : apply_div ? cfc_freq_s'{mult: o_clk_setting.mult,
                                                  div:  new_div}
                        : o_clk_setting;                          // [RULE7] [RULE13] [RULE18]

    // ----------------------------------------------------------------
    // Synchronisers for pins
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            mode_s1 <= i_mode_pins;
            mode_s2 <= mode_s1;
            wake_s1 <= i_wake_irq;
            wake_s2 <= wake_s1;
        end
    end

    // Power-on mode capture once the synchroniser is filled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_cnt <= 2'h0;
        end else if (por_cnt != 2'h3) begin
            por_cnt <= 2'(por_cnt + 2'h1);
        end
    end

    // Clock mode latch: at power-on and on deferred standby entry
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_clock_mode <= 3'h0;
        end else if (catch_por || (go_standby && defer)) begin
            o_clock_mode <= mode_s2;                              // [RULE17]
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phy_src <= RST_PHY_SRC;                               // [RULE2]
            phy_div <= RST_PHY_DIV;                               // [RULE3]
        end else if (wr_phy) begin
            phy_src <= i_bus.wdata[PHY_SRC_LSB +: 2];
            phy_div <= i_bus.wdata[PHY_DIV_LSB +: 3];
        end
    end

    // Frequency register; reset values are x1 and /4
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            freq <= '{mult: RST_MUL, div: RST_DIV};               // [RULE8] [RULE15]
        end else if (wr_freq) begin
            freq <= '{mult: new_mul, div: new_div};               // [RULE23] [RULE24]
        end
    end

    // Standby control and watchdog control bits
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            standby_request_bit_req <= 1'b0;
            defer    <= 1'b0;
            wdt_run  <= 1'b0;
            wdt_cks  <= 3'h0;
        end else begin
            if (wr_standby_request_bit) begin
                standby_request_bit_req <= i_bus.wdata[STANDBY_REQUEST_BIT_REQ_BIT];
                defer    <= i_bus.wdata[DEFER_BIT];
            end
            if (wr_wcsr) begin
                wdt_run <= i_bus.wdata[WDT_RUN_BIT];
                wdt_cks <= i_bus.wdata[WDT_CKS_LSB +: 3];
            end
        end
    end

    // Deferred change pending until the post-standby overflow
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending <= 1'b0;
        end else if (wr_freq && defer) begin
            pending <= 1'b1;                                      // [RULE18] [RULE22]
        end else if (apply_all && state == CFC_WAKE) begin
            pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer state and clock gates
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state            <= CFC_RUN;
            o_clk_setting    <= '{mult: RST_MUL, div: RST_DIV};
            o_core_clk_run   <= 1'b1;
            o_bus_clk_run    <= 1'b1;
            o_edge_detect_en <= 1'b1;
        end else begin
            state            <= next_state;
            o_clk_setting    <= next_applied;
            o_core_clk_run   <= next_state == CFC_RUN;
            o_bus_clk_run    <= next_state != CFC_STANDBY;        // [RULE10]
            o_edge_detect_en <= next_state == CFC_RUN;            // [RULE12]
        end
    end

    // ----------------------------------------------------------------
    // Read path, answered one cycle after the strobe
    // ----------------------------------------------------------------
    assign rd_mux =
        i_bus.addr == OFS_PHY_CTRL ? {8'h00, phy_src, 3'h0, phy_div} // [RULE4]
      : i_bus.addr == OFS_FREQ     ? {5'h00, freq.mult, 5'h00, freq.div}
      : i_bus.addr == OFS_STANDBY_REQUEST_BIT     ? {14'h0000, defer, standby_request_bit_req}
      : i_bus.addr == OFS_WDT_CNT  ? {8'h00, wdt_count}
      : i_bus.addr == OFS_WDT_CSR  ? {8'h00, wdt_run, 4'h0, wdt_cks}
      : i_bus.addr == OFS_STATUS   ? {8'h00, pending, o_clock_mode,
                                      2'h0, state}
      : 16'h0000;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_bus.rd ? rd_mux : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    cfc_wdt u_wdt (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_load     (wr_wcnt),
        .i_load_val (i_bus.wdata[7:0]),
        .i_cks      (wdt_cks),
        .i_count_en (wdt_cnt_en),
        .o_count    (wdt_count),
        .o_ovf      (wdt_ovf)
    );

    // PHY clock depends on the PHY control register alone
    cfc_phy_clkdiv u_phy (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_div_code (phy_div),                                    // [RULE5]
        .o_phy_clk  (o_phy_clk)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    key_ignore_a: assert property (                               // [RULE25]
        (i_bus.wr && i_bus.addr == OFS_PHY_CTRL && wkey != KEY_PHY)
        |=> $stable(phy_div) && $stable(phy_src))
        else $error("PHY control changed on wrong key");

    phy_rsvd_a: assert property (                                 // [RULE4]
        (i_bus.rd && i_bus.addr == OFS_PHY_CTRL)
        |=> o_rdata[15:8] == 8'h00 && o_rdata[5:3] == 3'h0)
        else $error("PHY control reserved bits not zero");

    mult_pause_a: assert property (                               // [RULE10]
        start_pause |=> !o_core_clk_run && o_bus_clk_run
        && $stable(o_clk_setting))
        else $error("Multiplier write did not pause core");

    div_now_a: assert property (                                  // [RULE14]
        apply_div |=> o_core_clk_run
        && o_clk_setting.div == $past(new_div))
        else $error("Divider change not immediate");

    defer_hold_a: assert property (                               // [RULE13]
        (wr_freq && defer) |=> $stable(o_clk_setting) && o_core_clk_run)
        else $error("Deferred write changed clocks");

    ovf_resume_a: assert property (                               // [RULE11]
        (state == CFC_PAUSE && wdt_ovf) |=> o_core_clk_run
        && o_clk_setting == freq && state == CFC_RUN ##1 !wdt_cnt_en
        || wdt_run)
        else $error("Overflow did not resume with new clocks");

    edge_off_a: assert property (                                 // [RULE12]
        (state != CFC_RUN) |-> !o_edge_detect_en && !o_core_clk_run)
        else $error("Edge detection active while paused");

    pend_hold_a: assert property (                                // [RULE22]
        (wr_freq && pending) |=> $stable(o_clk_setting))
        else $error("Pending change switched on a later write");

    phy_only_a: assert property (                                 // [RULE5]
        (wr_phy && state == CFC_RUN) |=> $stable(o_clk_setting))
        else $error("PHY control write moved core clocks");

    reset_val_a: assert property (                    // [RULE8] [RULE15]
        $rose(i_rst_n) |-> o_clk_setting.mult == RST_MUL
        && o_clk_setting.div == RST_DIV)
        else $error("Clock setting not at reset value");

    mode_sample_a: assert property (                              // [RULE17]
        (go_standby && defer) |=> o_clock_mode == $past(mode_s2)
        && state == CFC_STANDBY)
        else $error("Mode pins not sampled at standby entry");

    wake_apply_a: assert property (                               // [RULE20]
        (state == CFC_WAKE && wdt_ovf && pending)
        |=> o_clk_setting == $past(freq) && !pending)
        else $error("Deferred value not applied after standby");

    pause_cov: cover property (start_pause ##[1:600] wdt_ovf);
    standby_cov: cover property (go_standby && defer ##[1:50] wake_s2);
    div_cov: cover property (apply_div);
    wake_cov: cover property (state == CFC_WAKE && wdt_ovf && pending);
endmodule

// >>> logic/cfc_pkg.sv
package cfc_pkg;

    // ----------------------------------------------------------------
    // Register map and keys
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PHY_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ     = 8'h04;
    localparam logic [7:0] OFS_STANDBY_REQUEST_BIT     = 8'h08;
    localparam logic [7:0] OFS_WDT_CNT  = 8'h0C;
    localparam logic [7:0] OFS_WDT_CSR  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] KEY_PHY      = 8'h5A;
    localparam logic [7:0] KEY_WDT_CNT  = 8'h5A;
    localparam logic [7:0] KEY_WDT_CSR  = 8'hA5;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PHY_SRC_LSB  = 6;
    localparam int PHY_DIV_LSB  = 0;
    localparam int FREQ_MUL_LSB = 8;
    localparam int FREQ_DIV_LSB = 0;
    localparam int STANDBY_REQUEST_BIT_REQ_BIT = 0;
    localparam int DEFER_BIT    = 1;
    localparam int WDT_RUN_BIT  = 7;
    localparam int WDT_CKS_LSB  = 0;

    // ----------------------------------------------------------------
    // Codes and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] DIV_X1       = 3'h0;
    localparam logic [2:0] DIV_X2       = 3'h1;
    localparam logic [2:0] DIV_X4       = 3'h3;
    localparam logic [2:0] MUL_X1       = 3'h0;
    localparam logic [2:0] MUL_X2       = 3'h1;
    localparam logic [1:0] RST_PHY_SRC  = 2'h1;
    localparam logic [2:0] RST_PHY_DIV  = DIV_X4;
    localparam logic [2:0] RST_MUL      = MUL_X1;
    localparam logic [2:0] RST_DIV      = DIV_X4;
    localparam logic [1:0] POR_CATCH    = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] mult;
        logic [2:0] div;
    } cfc_freq_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } cfc_bus_s;

    typedef enum logic [1:0] {
        CFC_RUN     = 2'b00,
        CFC_STANDBY = 2'b01,
        CFC_WAKE    = 2'b11,
        CFC_PAUSE   = 2'b10
    } cfc_state_e;

endpackage

// >>> logic/cfc_phy_clkdiv.sv
`timescale 1ns/100ps
module cfc_phy_clkdiv (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_div_code,
    output logic            o_phy_clk
);
    import cfc_pkg::*;

    // ----------------------------------------------------------------
    // Last count of each half period (half period minus one) per divider code
    // ----------------------------------------------------------------
    function automatic logic [1:0] half_last(input logic [2:0] code);
        case (code)
            DIV_X1:  half_last = 2'h0;
            DIV_X2:  half_last = 2'h1;
            default: half_last = 2'h3;
        endcase
    endfunction

    logic [1:0] cnt;
    wire        wrap = (cnt >= half_last(i_div_code));

    // Toggle the PHY clock at the end of each half period
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt       <= 2'h0;
            o_phy_clk <= 1'b0;
        end else begin
            cnt       <= wrap ? 2'h0 : 2'(cnt + 2'h1);
            o_phy_clk <= wrap ? ~o_phy_clk : o_phy_clk;
        end
    end
endmodule

// >>> logic/cfc_wdt.sv
`timescale 1ns/100ps
module cfc_wdt (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    input  wire logic [2:0] i_cks,
    input  wire logic       i_count_en,
    output logic [7:0]      o_count,
    output logic            o_ovf
);
    import cfc_pkg::*;

    // ----------------------------------------------------------------
    // Prescaler mask per clock select (x1 down to x1/4096)
    // ----------------------------------------------------------------
    function automatic logic [11:0] cks_mask(input logic [2:0] cks);
        case (cks)
            3'h0:    cks_mask = 12'h000;
            3'h1:    cks_mask = 12'h003;
            3'h2:    cks_mask = 12'h00F;
            3'h3:    cks_mask = 12'h01F;
            3'h4:    cks_mask = 12'h03F;
            3'h5:    cks_mask = 12'h0FF;
            3'h6:    cks_mask = 12'h3FF;
            default: cks_mask = 12'hFFF;
        endcase
    endfunction

    logic [11:0] pre;
    wire         tick = i_count_en
                        && ((pre & cks_mask(i_cks)) == cks_mask(i_cks));
    wire         wrap = tick && (o_count == 8'hFF);

    // Prescaler runs only while counting is enabled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre <= 12'h000;
        end else begin
            pre <= i_count_en ? 12'(pre + 12'h001) : 12'h000;
        end
    end

    // Counter with load priority; overflow is a one-cycle pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count <= 8'h00;
            o_ovf   <= 1'b0;
        end else begin
            o_count <= i_load ? i_load_val
                     : (tick ? 8'(o_count + 8'h01) : o_count);
            o_ovf   <= wrap && !i_load;
        end
    end
endmodule

// >>> verif/cfc_phy_model.sv
`timescale 1ns/100ps
// -------------------------------------------------------------
// External PHY: times its clock while out of reset
// -------------------------------------------------------------
module cfc_phy_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_phy_clk,
    input  wire logic       i_rst_hold,
    output logic [3:0]      o_half_per
);
    logic [3:0] cnt;
    logic       last;

    // Held in reset it ignores the clock, so switch glitches go unseen
    always_ff @(posedge i_clk_sys) begin
        last <= i_phy_clk;
        if (i_rst_hold) begin
            cnt        <= 4'h0;
            o_half_per <= 4'h0;
        end else if (i_phy_clk != last) begin
            o_half_per <= cnt + 4'h1;
            cnt        <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// >>> verif/clock_frequency_change_control_test.sv
`timescale 1ns/100ps
module clock_frequency_change_control_test;
    import cfc_pkg::*;
    logic        i_clk_sys;
    logic        i_rst_n;
    logic        i_sleep;
    logic        i_wake_irq;
    logic        phy_hold;
    cfc_bus_s    bus;
    logic [2:0]  mode_pins;
    logic [15:0] rdata;
    cfc_freq_s   setting;
    logic [2:0]  clk_mode;
    logic        core_run;
    logic        bus_run;
    logic        edge_en;
    logic        phy_clk;
    logic [3:0]  half_per;
    logic [7:0]  key;
    logic [1:0]  src;
    logic [2:0]  code;
    int          n_errors;
    int          checks_done;
    int          seed_rv;
    logic [2:0]  codes [3] = '{3'h0, 3'h1, 3'h3};

    cfc_clock_ctrl cfc_clock_ctrl_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_bus(bus), .i_sleep(i_sleep), .i_wake_irq(i_wake_irq),
        .i_mode_pins(mode_pins), .o_rdata(rdata), .o_clk_setting(setting),
        .o_clock_mode(clk_mode), .o_core_clk_run(core_run),
        .o_bus_clk_run(bus_run), .o_edge_detect_en(edge_en),
        .o_phy_clk(phy_clk));
    cfc_phy_model cfc_phy_model_i (.i_clk_sys(i_clk_sys), .i_phy_clk(phy_clk),
        .i_rst_hold(phy_hold), .o_half_per(half_per));

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [3:0] half_of(input logic [2:0] c);
        return (c == 3'h0) ? 4'h1 : (c == 3'h1) ? 4'h2 : 4'h4;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One-cycle strobes, released at the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge i_clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
                      input string what);
        @(posedge i_clk_sys);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        #1 chk(what, e, rdata);
    endtask
    task automatic wait_run();
        for (int i = 0; i < 2000 && core_run !== 1'b1; i++)
            @(posedge i_clk_sys);
        #1;
        if (core_run !== 1'b1) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic wdt_load();
        wr(OFS_WDT_CSR, 16'hA500);
        wr(OFS_WDT_CNT, {KEY_WDT_CNT, 4'hF, 4'($urandom)});
    endtask

    // Clock source
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        {i_rst_n, i_sleep, i_wake_irq, bus} = '0;
        mode_pins = 3'h2;
        phy_hold = 1'b1;
        n_errors = 0;
        checks_done = 0;
        seed_rv = $urandom(32'h95C0E4EE);
        repeat (12) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        rd(OFS_PHY_CTRL, 16'h0043, "phy ctrl");
        rd(OFS_FREQ, 16'h0003, "freq");
        rd(8'hFC, 16'h0000, "unmapped");
        chk("mode", {13'h0, mode_pins}, {13'h0, clk_mode});
        $display("test reset done");
        // PHY divider codes, random source, PHY held in reset meanwhile
        for (int k = 0; k < 6; k++) begin
            src = 2'($urandom % 2);
            code = codes[k % 3];
            phy_hold <= 1'b1;
            wr(OFS_PHY_CTRL, {KEY_PHY, src, 3'h0, code});
            phy_hold <= 1'b0;
            repeat (20) @(posedge i_clk_sys);
            #1;
            chk("half", {12'h0, half_of(code)}, {12'h0, half_per});
            rd(OFS_PHY_CTRL, {8'h0, src, 3'h0, code}, "phy rb");
            chk("setting", 16'h0003, {10'h0, setting});
            key = 8'($urandom);
            if (key == KEY_PHY)
                key = 8'h00;
            wr(OFS_PHY_CTRL, {key, 8'h41});
            rd(OFS_PHY_CTRL, {8'h0, src, 3'h0, code}, "bad key");
        end
        $display("test phy clock done");
        // Divider-only changes switch at once; PHY held until the final PHY check
        phy_hold <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_FREQ, {5'h0, MUL_X1, 5'h0, codes[k]});
            chk("div", {13'h0, codes[k]}, {13'h0, setting.div});
            chk("run", 16'h1, {15'h0, core_run});
        end
        $display("test divider done");
        // Multiplier change pauses until the watchdog overflows
        phy_hold <= 1'b1;
        wdt_load();
        wr(OFS_FREQ, {5'h0, MUL_X2, 5'h0, DIV_X2});
        chk("pause", 16'h1, {13'h0, core_run, edge_en, bus_run});
        wait_run();
        chk("mult", {10'h0, MUL_X2, DIV_X2}, {10'h0, setting});
        chk("edge", 16'h1, {15'h0, edge_en});
        $display("test multiplier done");
        // Deferred change across software standby
        @(posedge i_clk_sys);
        mode_pins <= 3'($urandom);
        wr(OFS_STANDBY_REQUEST_BIT, 16'h0003);
        wdt_load();
        wr(OFS_FREQ, {5'h0, MUL_X1, 5'h0, DIV_X4});
        chk("deferred", {10'h0, MUL_X2, DIV_X2}, {10'h0, setting});
        wr(OFS_FREQ, {5'h0, MUL_X1, 5'h0, DIV_X1});
        chk("div pend", {10'h0, MUL_X2, DIV_X2}, {10'h0, setting});
        @(posedge i_clk_sys);
        i_sleep <= 1'b1;
        @(posedge i_clk_sys);
        i_sleep <= 1'b0;
        #1 chk("standby", 16'h0, {14'h0, core_run, bus_run});
        chk("mode", {13'h0, mode_pins}, {13'h0, clk_mode});
        @(posedge i_clk_sys);
        i_wake_irq <= 1'b1;
        wait_run();
        chk("wake", {10'h0, MUL_X1, DIV_X1}, {10'h0, setting});
        rd(OFS_STATUS, {8'h0, 1'b0, mode_pins, 4'h0}, "status");
        @(posedge i_clk_sys);
        i_wake_irq <= 1'b0;
        wr(OFS_STANDBY_REQUEST_BIT, 16'h0000);
        chk("bus", 16'h1, {15'h0, bus_run});
        // PHY clock kept its own divider through all core changes
        phy_hold <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        #1;
        chk("phy end", {12'h0, half_of(code)}, {12'h0, half_per});
        $display("test deferred done");
        close_out();
    end
endmodule
